/* hw/scope_pkg.sv */
// Purpose: shared constants and types for the scope shot capture
// Assumes: one clock, registers reached over APB with byte addresses
// Notes: register layout and command bits live here only
// How it works
// - One capture channel; its source is picked from two inputs.
// - Every full-rate input sample enters the rate reducer.
// - Shot length is configurable, at most 64000 samples.
// - Shot spans length times the reduced sample period.
// - Decimation keeps one sample of each N, drops the rest.
// - Block averaging outputs the mean of N full-rate samples.
// - Block averaging is the reset default; a bit selects decimation.
// - Reduction factor N is always two to an integer power.
// - Captured values are 14 bits wide.
// - Mixer mode records in-phase and quadrature traces.
// - Optional exponential moving average over shots, depth configurable.
// - Depth is the shot count to reach about 63% settling.
// - Average clear command restarts the shot averaging.
// - With trigger on, a shot starts only on the trigger condition.
// - With trigger off, an armed shot starts at once; each next shot waits for the acknowledge.
// - A single request records exactly one shot, then stops.
package scope_pkg;
  localparam int SAMPLE_W = 14;
  localparam int LEN_W = 16;
  localparam int MAX_LEN = 64000;
  localparam logic [LEN_W-1:0] LEN_MAX = 16'hFA00;
  localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
  localparam logic [LEN_W-1:0] LEN_RESET = 16'h0400;
  localparam int EXP_W = 5;
  localparam int MAX_RATE_EXP = 21;
  localparam logic [EXP_W-1:0] RATE_EXP_MAX = 5'h15;
  localparam int SUM_W = SAMPLE_W + MAX_RATE_EXP + 1;
  localparam int AVG_W = 4;
  localparam logic [AVG_W-1:0] AVG_EXP_MAX = 4'hC;
  localparam int FRAC_W = 12;
  localparam int ACC_W = SAMPLE_W + FRAC_W;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LEN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TLEVEL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RD_INDEX = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RD_DATA = 8'h18;
  // Control register fields
  localparam int CTRL_SRC = 0;
  localparam int CTRL_DECIM = 1;
  localparam int CTRL_MIX = 2;
  localparam int CTRL_AVG = 3;
  localparam int CTRL_TRIG = 4;
  localparam int CTRL_TSRC = 5;
  localparam int CTRL_TFALL = 6;
  localparam int CTRL_RUN = 7;
  localparam int CTRL_RATE_LSB = 8;
  localparam int CTRL_AVGK_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Command and status bits
  localparam int CMD_SINGLE = 0;
  localparam int CMD_ACK = 1;
  localparam int CMD_AVG_CLR = 2;
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_PRIMED = 2;
  localparam int STAT_COUNT_LSB = 16;
  localparam int HALF_W = 16;

  typedef logic signed [SAMPLE_W-1:0] sample_t;
  typedef struct packed {
    sample_t raw;
    sample_t mix_i;
    sample_t mix_q;
  } scope_in_t;
  typedef struct packed {
    logic signed [ACC_W-1:0] i;
    logic signed [ACC_W-1:0] q;
  } acc_t;
  typedef enum logic [1:0] {
    IDLE,
    ARM,
    CAPTURE,
    DONE
  } shot_state_t;
endpackage

/* hw/rate_reducer.sv */
// Purpose: reduce the full sample rate by a power of two
// Assumes: in_valid marks one full-rate sample
// Notes: clear realigns the block to the next input sample
`timescale 1ns/1ps
module rate_reducer (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        clear,
  input  wire logic                        in_valid,
  input  wire scope_pkg::sample_t          in_data,
  input  wire logic [scope_pkg::EXP_W-1:0] rate_exp,
  input  wire logic                        decimate,
  output logic                             out_valid,
  output scope_pkg::sample_t               out_data
);
  import scope_pkg::*;

  logic [MAX_RATE_EXP-1:0] cnt;
  logic [MAX_RATE_EXP-1:0] mask;
  logic signed [SUM_W-1:0] sum;
  logic signed [SUM_W-1:0] total;
  logic                    last;

  // Block of N = 2^exp samples; mask marks the last one
  assign mask = ~({MAX_RATE_EXP{1'b1}} << rate_exp);
  // A count left past the mask by a rate change ends the block at once
  assign last = (cnt >= mask);
  assign total = sum + SUM_W'(in_data);

  // Accumulate and emit one sample per block
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      sum <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clear) begin
      cnt <= '0;
      sum <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid && last;
      if (in_valid && last) begin
        cnt <= '0;
        sum <= '0;
        if (decimate) begin
          out_data <= in_data;
        end else begin
          out_data <= SAMPLE_W'(total >>> rate_exp);
        end
      end else if (in_valid) begin
        cnt <= cnt + 1'b1;
        sum <= total;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  decim_pass_a: assert property (in_valid && last && decimate && !clear
    |=> out_valid && out_data == $past(in_data))
    else $error("decimated sample differs from input");
  full_rate_a: assert property (in_valid && rate_exp == '0 && !clear
    |=> out_valid)
    else $error("unit factor did not pass every sample");
endmodule

/* hw/scope_shot_capture.sv */
// Purpose: shot capture engine with rate reduction, trigger and averaging
// Assumes: sample_valid marks one full-rate sample of both inputs
// Notes: APB slave with one wait state; shot buffer is flip-flops
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module scope_shot_capture (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [scope_pkg::ADDR_W-1:0] paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         sample_valid,
  input  wire scope_pkg::scope_in_t [1:0]   sig_in,
  output logic                              shot_done,
  output logic                              capture_busy
);
  import scope_pkg::*;

  // Software state
  logic [31:0]      ctrl;
  logic [LEN_W-1:0] shot_len;
  sample_t          trig_level;
  logic [LEN_W-1:0] rd_index;

  // Engine state
  shot_state_t      state;
  logic [LEN_W-1:0] wr_idx;
  logic             avg_primed;
  logic             single_req;
  logic [15:0]      shot_count;
  sample_t          prev_trig;
  acc_t             mem [MAX_LEN];

  // Decoded controls
  logic             run;
  logic             trig_en;
  logic             avg_en;
  logic [EXP_W-1:0] rate_exp;
  logic [AVG_W-1:0] avg_exp;
  logic [LEN_W-1:0] eff_len;
  logic [LEN_W-1:0] rd_sel;
  logic             rd_hit;

  // Bus strobes
  logic answer;
  logic wr_en;
  logic cmd_wr;
  logic cmd_single;
  logic cmd_ack;
  logic cmd_avg_clr;
  logic known_addr;

  // Datapath
  scope_in_t      src;
  sample_t        red_in [2];
  sample_t        red_out [2];
  logic [1:0]     red_valid;
  sample_t        trig_cur;
  logic           trig_hit;
  logic           start;
  logic           store;
  logic           last_store;
  logic           blend;
  acc_t           old_entry;
  acc_t           next_entry;
  acc_t           rd_entry;

  // Control fields, clamped to legal ranges
  assign run = ctrl[CTRL_RUN];
  assign trig_en = ctrl[CTRL_TRIG];
  assign avg_en = ctrl[CTRL_AVG];
  always_comb begin
    rate_exp = ctrl[CTRL_RATE_LSB +: EXP_W];
    if (rate_exp > RATE_EXP_MAX) begin
      rate_exp = RATE_EXP_MAX;
    end
    avg_exp = ctrl[CTRL_AVGK_LSB +: AVG_W];
    if (avg_exp > AVG_EXP_MAX) begin
      avg_exp = AVG_EXP_MAX;
    end
  end

  // Zero length would never finish, so it counts as one
  always_comb begin
    eff_len = shot_len;
    if (shot_len == '0) begin
      eff_len = LEN_ONE;
    end else if (shot_len > LEN_MAX) begin
      eff_len = LEN_MAX;
    end
  end

  // APB: answer one cycle into the access phase; write on the pready edge
  assign answer = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;
  assign cmd_wr = wr_en && (paddr == OFF_CMD);
  assign cmd_single = cmd_wr && pwdata[CMD_SINGLE];
  assign cmd_ack = cmd_wr && pwdata[CMD_ACK];
  assign cmd_avg_clr = cmd_wr && pwdata[CMD_AVG_CLR];
  assign known_addr = (paddr == OFF_CTRL) || (paddr == OFF_CMD) ||
                      (paddr == OFF_LEN) || (paddr == OFF_TLEVEL) ||
                      (paddr == OFF_STATUS) || (paddr == OFF_RD_INDEX) ||
                      (paddr == OFF_RD_DATA);

  // Out-of-range index reads as zero rather than past the array
  assign rd_hit = rd_index < LEN_MAX;
  assign rd_sel = rd_hit ? rd_index : '0;
  assign rd_entry = mem[rd_sel];

  // Ready, error and read data all registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= answer;
      pslverr <= answer && !known_addr;
      prdata <= '0;
      if (answer && !pwrite) begin
        case (paddr)
          OFF_CTRL: prdata <= ctrl;
          OFF_LEN: prdata <= 32'(eff_len);
          OFF_TLEVEL: prdata <= 32'(trig_level);
          OFF_RD_INDEX: prdata <= 32'(rd_index);
          OFF_STATUS: begin
            prdata[STAT_DONE] <= shot_done;
            prdata[STAT_BUSY] <= capture_busy;
            prdata[STAT_PRIMED] <= avg_primed;
            prdata[STAT_COUNT_LSB +: HALF_W] <= shot_count;
          end
          OFF_RD_DATA: begin
            if (rd_hit) begin
              prdata[0 +: HALF_W] <= HALF_W'(sample_t'(rd_entry.i[ACC_W-1:FRAC_W]));
              prdata[HALF_W +: HALF_W] <= HALF_W'(sample_t'(rd_entry.q[ACC_W-1:FRAC_W]));
            end
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Writable configuration; reset selects block averaging
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      shot_len <= LEN_RESET;
      trig_level <= '0;
      rd_index <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFF_CTRL: ctrl <= pwdata;
        OFF_LEN: shot_len <= pwdata[LEN_W-1:0];
        OFF_TLEVEL: trig_level <= pwdata[SAMPLE_W-1:0];
        OFF_RD_INDEX: rd_index <= pwdata[LEN_W-1:0];
        default: ;
      endcase
    end
  end

  // Channel source and component selection
  assign src = sig_in[ctrl[CTRL_SRC]];
  always_comb begin
    if (ctrl[CTRL_MIX]) begin
      red_in[0] = src.mix_i;
      red_in[1] = src.mix_q;
    end else begin
      red_in[0] = src.raw;
      red_in[1] = '0;
    end
  end

  // One reducer per component, both cleared at shot start
  for (genvar c = 0; c < 2; c++) begin : g_red
    rate_reducer u_red (
      .clk       (clk),
      .nrst      (nrst),
      .clear     (start),
      .in_valid  (sample_valid),
      .in_data   (red_in[c]),
      .rate_exp  (rate_exp),
      .decimate  (ctrl[CTRL_DECIM]),
      .out_valid (red_valid[c]),
      .out_data  (red_out[c])
    );
  end

  // Level crossing on the chosen trigger input
  assign trig_cur = sig_in[ctrl[CTRL_TSRC]].raw;
  always_comb begin
    if (ctrl[CTRL_TFALL]) begin
      trig_hit = sample_valid && (prev_trig > trig_level) && (trig_cur <= trig_level);
    end else begin
      trig_hit = sample_valid && (prev_trig < trig_level) && (trig_cur >= trig_level);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_trig <= '0;
    end else if (sample_valid) begin
      prev_trig <= trig_cur;
    end
  end

  // Shot sequencing strobes
  assign start = (state == ARM) && (run || single_req) &&
                 (!trig_en || trig_hit);
  assign store = (state == CAPTURE) && red_valid[0];
  // Length cut below the pointer mid-shot still ends the shot
  assign last_store = store && (wr_idx >= eff_len - LEN_ONE);

  // Shot state machine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE: begin
          if (run || cmd_single) begin
            state <= ARM;
          end
        end
        ARM: begin
          if (!(run || single_req)) begin
            state <= IDLE;
          end else if (start) begin
            state <= CAPTURE;
          end
        end
        CAPTURE: begin
          if (last_store) begin
            state <= DONE;
          end
        end
        DONE: begin
          if (cmd_ack) begin
            state <= run ? ARM : IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Single request lives until its shot is stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      single_req <= 1'b0;
    end else if (last_store) begin
      single_req <= 1'b0;
    end else if (cmd_single && (state == IDLE || state == ARM)) begin
      single_req <= 1'b1;
    end
  end

  // Write pointer restarts at each shot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_idx <= '0;
    end else if (start) begin
      wr_idx <= '0;
    end else if (store) begin
      wr_idx <= wr_idx + LEN_ONE;
    end
  end

  // Done flag: hardware set wins over acknowledge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shot_done <= 1'b0;
      capture_busy <= 1'b0;
      shot_count <= '0;
    end else begin
      if (last_store) begin
        shot_done <= 1'b1;
        shot_count <= shot_count + 1'b1;
      end else if (cmd_ack) begin
        shot_done <= 1'b0;
      end
      capture_busy <= (state == ARM) || (state == CAPTURE);
    end
  end

  // Averaging primed after a full shot; clear command or disable restarts it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avg_primed <= 1'b0;
    end else if (last_store && avg_en) begin
      avg_primed <= 1'b1;
    end else if (cmd_avg_clr || !avg_en) begin
      avg_primed <= 1'b0;
    end
  end

  // Exponential average: weight 2^-k settles ~63% after 2^k shots
  assign blend = avg_en && avg_primed;
  assign old_entry = mem[wr_idx];
  always_comb begin
    logic signed [ACC_W:0] xi;
    logic signed [ACC_W:0] xq;
    xi = {red_out[0][SAMPLE_W-1], red_out[0], {FRAC_W{1'b0}}};
    xq = {red_out[1][SAMPLE_W-1], red_out[1], {FRAC_W{1'b0}}};
    next_entry.i = ACC_W'(xi);
    next_entry.q = ACC_W'(xq);
    if (blend) begin
      next_entry.i = ACC_W'(old_entry.i + ACC_W'((xi - old_entry.i) >>> avg_exp));
      next_entry.q = ACC_W'(old_entry.q + ACC_W'((xq - old_entry.q) >>> avg_exp));
    end
  end

  // Shot buffer; no reset, contents only meaningful after a shot
  always_ff @(posedge clk) begin
    if (store) begin
      mem[wr_idx] <= next_entry;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  apb_answer_a: assert property (answer |=> pready ##1 !pready)
    else $error("APB answer not one cycle");
  done_hold_a: assert property (state == DONE && !cmd_ack |=> state == DONE)
    else $error("done state left without acknowledge");
  buffer_stable_a: assert property (state == DONE |-> !store)
    else $error("buffer written while held");
  len_limit_a: assert property (store |-> wr_idx < eff_len && wr_idx < LEN_MAX)
    else $error("write beyond shot length");
  trig_wait_a: assert property (state == ARM && trig_en && !trig_hit
    |=> state != CAPTURE)
    else $error("shot began without trigger");
  free_run_a: assert property (state == ARM && run && !trig_en |=> state == CAPTURE)
    else $error("free run did not start");
  single_stop_a: assert property (state == DONE && cmd_ack && !run
    |=> state == IDLE && !single_req)
    else $error("single shot did not stop");
  lanes_aligned_a: assert property (red_valid[0] == red_valid[1])
    else $error("component reducers out of step");
  avg_clear_a: assert property (cmd_avg_clr && !last_store |=> !avg_primed)
    else $error("average state not cleared");
  done_flag_a: assert property (last_store |=> shot_done && state == DONE)
    else $error("done flag missing after last sample");

  single_shot_c: cover property (cmd_single ##[1:300] last_store);
  trig_shot_c: cover property (trig_en && trig_hit && state == ARM);
  blend_shot_c: cover property (blend && last_store);
  decim_shot_c: cover property (ctrl[CTRL_DECIM] && last_store);
endmodule

/* testbench/sample_source.sv */
// Purpose: front-end model that feeds full-rate samples to the capture block
// Assumes: pattern of period four, so a block mean is the same at any alignment
// Notes: between samples the data lines carry the inverse, never stale values
`timescale 1ns/1ps
module sample_source (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       slow,
  input  wire scope_pkg::sample_t         amp,
  output logic                            sample_valid,
  output scope_pkg::scope_in_t [1:0]      sig_in
);
  import scope_pkg::*;
  logic [1:0]      phase;
  logic            gap;
  sample_t         v;
  scope_in_t [1:0] pat;

  // Pulse every cycle, or every other cycle to model a slow front end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase        <= 2'h0;
      gap          <= 1'b0;
      sample_valid <= 1'b0;
    end else begin
      gap          <= slow ? !gap : 1'b0;
      sample_valid <= !gap || !slow;
      if (sample_valid) phase <= phase + 2'h1;
    end
  end

  // Input 1 mirrors input 0; quadrature is a fixed offset
  assign v = (phase == 2'h3) ? amp : 14'h0000;
  always_comb begin
    pat[0] = '{raw: v, mix_i: v, mix_q: 14'h3FF9};
    pat[1] = '{raw: -v, mix_i: -v, mix_q: 14'h0007};
    sig_in = sample_valid ? pat : ~pat;
  end
endmodule

/* testbench/testbench.sv */
// Purpose: self-checking bench for the scope shot capture over APB
// Assumes: one-wait-state APB slave, source pattern 0,0,0,amp
// Notes: block mean of that pattern is amp/4 for any factor of four or more
`timescale 1ns/1ps
module testbench;
  import scope_pkg::*;
  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sample_valid;
  scope_in_t [1:0]   sig_in;
  logic              shot_done;
  logic              capture_busy;
  logic              slow;
  sample_t           amp;
  logic [31:0]       rd;
  logic [31:0]       first;
  logic              err;
  int                num_errors;
  int                compares;
  int                n;

  scope_shot_capture dut (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sig_in(sig_in), .shot_done(shot_done), .capture_busy(capture_busy));
  sample_source src (.clk(clk), .nrst(nrst), .slow(slow), .amp(amp),
    .sample_valid(sample_valid), .sig_in(sig_in));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  // One APB transfer; read data taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && t < 50) begin
      t++;
      @(posedge clk);
    end
    if (t == 50) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Skip the call's own edge, whose flags predate the last bus write
  task automatic wait_done(input int limit);
    @(posedge clk);
    n = 0;
    while (shot_done !== 1'b1 && n < limit) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, shot_done}, 32'h1);
  endtask

  // Configure, request one shot and wait for it
  task automatic shot(input logic [31:0] ctrl, input logic [31:0] len);
    apb(1'b1, OFF_CTRL, ctrl);
    apb(1'b1, OFF_LEN, len);
    apb(1'b1, OFF_CMD, 32'h1);
    wait_done(2000);
  endtask

  task automatic get(input int i);
    apb(1'b1, OFF_RD_INDEX, i);
    apb(1'b0, OFF_RD_DATA, 32'h0);
  endtask

  task automatic expect_all(input int cnt, input logic [31:0] want);
    for (int i = 0; i < cnt; i++) begin
      get(i);
      check(rd, want);
    end
  endtask

  task automatic conclude;
    $display("errors %0d, comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog well beyond the expected run time
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    slow = 1'b0;
    amp = 14'h0028;
    num_errors = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, length clamping, an unmapped address
    apb(1'b0, OFF_CTRL, 32'h0); check(rd, CTRL_RESET);
    apb(1'b0, OFF_LEN, 32'h0); check(rd, {16'h0, LEN_RESET});
    apb(1'b0, 8'h1C, 32'h0); check({31'h0, err}, 32'h1);
    apb(1'b1, OFF_LEN, 32'h0);
    apb(1'b0, OFF_LEN, 32'h0); check(rd, {16'h0, LEN_ONE});
    apb(1'b1, OFF_LEN, 32'hFFFF);
    apb(1'b0, OFF_LEN, 32'h0); check(rd, {16'h0, LEN_MAX});
    // Block averaging at factors 4 and 8, then single shot stops
    for (int e = 2; e < 4; e++) begin
      shot({24'h0, 3'h0, e[4:0]} << 8, 32'h4);
      expect_all(4, 32'h0000_000A);
      apb(1'b0, OFF_STATUS, 32'h0); check({31'h0, rd[STAT_DONE]}, 32'h1);
      apb(1'b1, OFF_CMD, 32'h2);
    end
    repeat (100) @(posedge clk);
    check({30'h0, shot_done, capture_busy}, 32'h0);
    // Decimation on input 1 keeps one phase of the pattern
    shot(32'h0000_0203, 32'h4);
    get(0);
    first = rd;
    check({31'h0, first == 32'h0 || first == 32'h0000_FFD8}, 32'h1);
    for (int i = 1; i < 4; i++) begin
      get(i);
      check(rd, first);
    end
    apb(1'b1, OFF_CMD, 32'h2);
    // Mixer mode on both inputs
    shot(32'h0000_0204, 32'h4);
    expect_all(4, 32'hFFF9_000A);
    apb(1'b1, OFF_CMD, 32'h2);
    shot(32'h0000_0205, 32'h2);
    expect_all(2, 32'h0007_FFF6);
    apb(1'b1, OFF_CMD, 32'h2);
    // Halving the input rate doubles the shot span
    slow <= 1'b1;
    shot(32'h0000_0200, 32'h4);
    check({31'h0, n >= 32 && n <= 40}, 32'h1);
    apb(1'b1, OFF_CMD, 32'h2);
    slow <= 1'b0;
    // Shot averaging with depth 2, then clear restarts it
    apb(1'b1, OFF_CMD, 32'h4);
    shot(32'h0001_0208, 32'h4);
    expect_all(4, 32'h0000_000A);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, {16'h0007, 13'h0, 3'h5});
    apb(1'b1, OFF_CMD, 32'h2);
    amp <= 14'h0050;
    shot(32'h0001_0208, 32'h4);
    expect_all(4, 32'h0000_000F);
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b1, OFF_CMD, 32'h4);
    shot(32'h0001_0208, 32'h4);
    expect_all(4, 32'h0000_0014);
    apb(1'b1, OFF_CMD, 32'h2);
    // Trigger level above the signal holds the shot back
    amp <= 14'h0028;
    apb(1'b1, OFF_CTRL, 32'h0000_0210);
    apb(1'b1, OFF_TLEVEL, 32'h0000_03E8);
    apb(1'b1, OFF_CMD, 32'h1);
    repeat (300) @(posedge clk);
    check({30'h0, shot_done, capture_busy}, 32'h1);
    amp <= 14'h07D0;
    wait_done(2000);
    get(0);
    check(rd, 32'h0000_01F4);
    apb(1'b1, OFF_CMD, 32'h2);
    // Continuous run needs no single request
    apb(1'b1, OFF_CTRL, 32'h0000_0280);
    wait_done(2000);
    apb(1'b1, OFF_CMD, 32'h2);
    wait_done(2000);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CMD, 32'h2);
    conclude();
  end
endmodule
